// ### src/abm_brk_unit.sv
// Purpose: Address break unit, device end
// Assumes: CPU holds each strobe for one cycle and ends a break by rti_done
// Notes:   Register read data appear the cycle after rd_en
//
// Operation
// R1 - PC address match raises break request
// R2 - CPU takes break through fixed vectors
// R3 - Only program counter addresses can match
// R4 - Writing one to break_active forces break
// R5 - Match on last cycle breaks immediately
// R6 - Return instruction ends the break
// R7 - Enable bit gates full address matches
// R8 - break_active sets on match, write zero clears
// R9 - Address bytes held, cleared by reset
// R10 - Timers halt during break
// R11 - Watchdog off in break with test voltage
// R12 - Wait flag marks break leaving wait
// R13 - Stop mode freezes unit and registers
// R14 - Status clears in break need enable
// R15 - Software may rewind return into wait
// R16 - Registers are eight-bit memory locations
//
// Our own choices: register access over AXI4-Lite and the register addresses.

`timescale 1ns/1ps

module abm_brk_unit
   import abm_pkg::*;
(
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_b,
   // CPU core connection
   abm_if.dev        cpu,
   // Test voltage present on the reset pin
   input  wire logic test_voltage,
   // System controls during break
   output logic      break_state_q,
   output logic      timer_halt_q,
   output logic      watchdog_off_q,
   output logic      status_clear_ok_q
);

   // ************************************************************
   // Storage
   // ************************************************************
   abm_state_t  state_q;
   abm_state_t  state_d;
   logic        ena_q;
   logic        ena_d;
   logic        act_q;
   logic        act_d;
   logic [7:0]  bah_q;
   logic [7:0]  bal_q;
   logic        bw_q;
   logic        bw_d;
   logic        clr_en_q;
   logic        clr_en_d;

   // ************************************************************
   // Address decode
   // ************************************************************

   // Registers only change while the core is not stopped
   wire         run_ok  = ~cpu.stop_mode;
   wire         wr_ok   = cpu.wr_en & run_ok;
   wire         sel_scr = (cpu.addr == ADR_SCR);
   wire         sel_bah = (cpu.addr == ADR_BAH);
   wire         sel_bal = (cpu.addr == ADR_BAL);
   wire         sel_wst = (cpu.addr == ADR_WST);
   wire         sel_fcr = (cpu.addr == ADR_FCR);

   // Write strobes per byte location
   wire         wr_scr = wr_ok & sel_scr;  // R16
   wire         wr_bah = wr_ok & sel_bah;  // R16
   wire         wr_bal = wr_ok & sel_bal;  // R16
   wire         wr_wst = wr_ok & sel_wst;  // R16
   wire         wr_fcr = wr_ok & sel_fcr;  // R16

   // ************************************************************
   // Break detection
   // ************************************************************

   // Stored 16-bit breakpoint
   wire [15:0]  brk_addr = {bah_q, bal_q};

   // Program counter match against the breakpoint
   wire         addr_eq = (cpu.addr == brk_addr);  // R1
   wire         pc_hit  = ena_q & cpu.pc_fetch & addr_eq & run_ok;  // R3 R7 R13

   // Software request by a one written to break_active
   wire         sw_brk = wr_scr & cpu.wdata[SCR_ACT_BIT];  // R4

   // A new break only starts from normal running
   wire         in_run    = (state_q == ABM_RUN);
   wire         brk_start = (pc_hit | sw_brk) & in_run;  // R1 R4

   // Break ends when the core returns from the routine
   wire         brk_end = (state_q == ABM_BRK) & cpu.rti_done;  // R6

   // ************************************************************
   // Next register values
   // ************************************************************

   // Enable bit follows writes only
   always_comb begin
      ena_d = ena_q;
      if (wr_scr) begin
         ena_d = cpu.wdata[SCR_ENA_BIT];  // R7
      end
   end

   // Active bit: a match wins over a clearing write
   always_comb begin
      act_d = act_q;
      if (wr_scr) begin
         act_d = cpu.wdata[SCR_ACT_BIT];  // R8
      end
      if (pc_hit) begin
         act_d = 1'b1;  // R8
      end
   end

   // Wait flag: set by a break during wait, cleared by a zero write
   always_comb begin
      bw_d = bw_q;
      if (wr_wst && !cpu.wdata[WST_BW_BIT]) begin
         bw_d = 1'b0;  // R12
      end
      if (brk_start && cpu.wait_mode) begin
         bw_d = 1'b1;  // R12 R15
      end
   end

   // Clear enable bit follows writes only
   always_comb begin
      clr_en_d = clr_en_q;
      if (wr_fcr) begin
         clr_en_d = cpu.wdata[FCR_CLR_BIT];
      end
   end

   // Break state sequence
   always_comb begin
      case (state_q)
         ABM_RUN: begin
            state_d = brk_start ? ABM_BRK : ABM_RUN;  // R5
         end
         ABM_BRK: begin
            state_d = brk_end ? ABM_RUN : ABM_BRK;  // R6
         end
         default: begin
            state_d = ABM_RUN;
         end
      endcase
   end

   // Break state as seen by the rest of the chip from the next cycle
   wire         brk_next = (state_d == ABM_BRK);

   // ************************************************************
   // Read path
   // ************************************************************

   // Reserved bits read as zero
   wire [7:0]   scr_rd = {ena_q, act_q, 6'h00};
   wire [7:0]   wst_rd = {6'h00, bw_q, 1'b0};
   wire [7:0]   fcr_rd = {clr_en_q, 7'h00};

   // Read data select, unmapped locations read zero
   wire [7:0]   rd_mux = sel_scr ? scr_rd :
                         sel_bah ? bah_q  :
                         sel_bal ? bal_q  :
                         sel_wst ? wst_rd :
                         sel_fcr ? fcr_rd : RST_BYTE;

   // ************************************************************
   // Registers
   // ************************************************************

   // Break control and status
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ena_q    <= 1'b0;  // R7
         act_q    <= 1'b0;  // R8
         bw_q     <= 1'b0;  // R12
         clr_en_q <= 1'b0;
         state_q  <= ABM_RUN;
      end else begin
         ena_q    <= ena_d;
         act_q    <= act_d;
         bw_q     <= bw_d;
         clr_en_q <= clr_en_d;
         state_q  <= state_d;
      end
   end

   // Breakpoint address bytes
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         bah_q <= RST_BYTE;  // R9
         bal_q <= RST_BYTE;  // R9
      end else begin
         if (wr_bah) begin
            bah_q <= cpu.wdata;  // R9
         end
         if (wr_bal) begin
            bal_q <= cpu.wdata;  // R9
         end
      end
   end

   // Request pulse and read answer toward the core
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cpu.break_req <= 1'b0;
         cpu.rdata     <= RST_BYTE;
      end else begin
         cpu.break_req <= brk_start;  // R1 R4
         cpu.rdata     <= cpu.rd_en ? rd_mux : RST_BYTE;  // R16
      end
   end

   // System controls during break
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         break_state_q     <= 1'b0;
         timer_halt_q      <= 1'b0;
         watchdog_off_q    <= 1'b0;
         status_clear_ok_q <= 1'b1;
      end else begin
         break_state_q     <= brk_next;
         timer_halt_q      <= brk_next;  // R10
         watchdog_off_q    <= brk_next & test_voltage;  // R11
         status_clear_ok_q <= ~brk_next | clr_en_d;  // R14
      end
   end

endmodule

// ### src/abm_pkg.sv
// Purpose: Shared constants and types for the address break module and its CPU end
// Assumes: 8-bit CPU register bus, 16-bit CPU address bus
// Notes:   Internal bus locations and host word offsets are fixed here only

package abm_pkg;

   // ************************************************************
   // Widths
   // ************************************************************
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int IRQ_W  = 3;

   // ************************************************************
   // Break unit locations on the CPU internal bus
   // ************************************************************
   localparam logic [15:0] ADR_SCR = 16'hff00;  // break_status_control
   localparam logic [15:0] ADR_BAH = 16'hff01;  // break_address_high
   localparam logic [15:0] ADR_BAL = 16'hff02;  // break_address_low
   localparam logic [15:0] ADR_WST = 16'hff03;  // break_wait_status
   localparam logic [15:0] ADR_FCR = 16'hff04;  // break_flag_control

   // Field positions and reset value of the break unit registers
   localparam int          SCR_ENA_BIT = 7;     // break_match_enable
   localparam int          SCR_ACT_BIT = 6;     // break_active
   localparam int          WST_BW_BIT  = 1;     // break_wait_flag
   localparam int          FCR_CLR_BIT = 7;     // status_clear_in_break_enable
   localparam logic [7:0]  RST_BYTE    = 8'h00;

   // Break vectors taken by the CPU
   localparam logic [15:0] VEC_USER = 16'hfffc;
   localparam logic [15:0] VEC_MON  = 16'hfefc;

   // ************************************************************
   // CPU end registers on AXI4-Lite (byte offsets)
   // ************************************************************
   localparam logic [7:0]  H_CTRL  = 8'h00;
   localparam logic [7:0]  H_ADDR  = 8'h04;
   localparam logic [7:0]  H_STAT  = 8'h08;
   localparam logic [7:0]  H_ISTAT = 8'h0c;
   localparam logic [7:0]  H_IMASK = 8'h10;

   // Control word fields
   localparam int C_GO   = 0;
   localparam int C_WR   = 1;
   localparam int C_PC   = 2;
   localparam int C_WAIT = 3;
   localparam int C_STOP = 4;
   localparam int C_MON  = 5;
   localparam int C_RTI  = 6;

   // Interrupt status fields
   localparam int I_BRK = 0;
   localparam int I_END = 1;
   localparam int I_ACC = 2;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Break unit operating state
   typedef enum logic [1:0] {
      ABM_RUN = 2'b01,
      ABM_BRK = 2'b10
   } abm_state_t;

endpackage

// ### src/abm_if.sv
// Purpose: Connection between the CPU core and the break unit
// Assumes: All signals change right after ref_clk rising edges
// Notes:   Strobes last one cycle; read data answer one cycle later

`timescale 1ns/1ps

interface abm_if;
   logic [15:0] addr;       // Internal address bus
   logic        pc_fetch;   // Address is a program counter value
   logic        wr_en;      // Register write strobe
   logic        rd_en;      // Register read strobe
   logic [7:0]  wdata;      // Write data
   logic        wait_mode;  // CPU in wait mode
   logic        stop_mode;  // CPU in stop mode
   logic        rti_done;   // Return from break routine executed
   logic [7:0]  rdata;      // Read data
   logic        break_req;  // Breakpoint request to CPU

   modport dev (
      input  addr, pc_fetch, wr_en, rd_en, wdata, wait_mode, stop_mode, rti_done,
      output rdata, break_req
   );
   modport cpu (
      output addr, pc_fetch, wr_en, rd_en, wdata, wait_mode, stop_mode, rti_done,
      input  rdata, break_req
   );
endinterface

// ### src/abm_cpu_end.sv
// Purpose: CPU core end of the break unit, ordered over AXI4-Lite
// Assumes: One AXI write and one AXI read under way at a time
// Notes:   Takes a break the cycle a request is seen

`timescale 1ns/1ps

module abm_cpu_end
   import abm_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   // AXI4-Lite write channels
   input  wire logic [7:0]  s_axil_awaddr,
   input  wire logic        s_axil_awvalid,
   output logic             s_axil_awready,
   input  wire logic [31:0] s_axil_wdata,
   input  wire logic [3:0]  s_axil_wstrb,
   input  wire logic        s_axil_wvalid,
   output logic             s_axil_wready,
   output logic [1:0]       s_axil_bresp,
   output logic             s_axil_bvalid,
   input  wire logic        s_axil_bready,
   // AXI4-Lite read channels
   input  wire logic [7:0]  s_axil_araddr,
   input  wire logic        s_axil_arvalid,
   output logic             s_axil_arready,
   output logic [31:0]      s_axil_rdata,
   output logic [1:0]       s_axil_rresp,
   output logic             s_axil_rvalid,
   input  wire logic        s_axil_rready,
   // Break unit connection
   abm_if.cpu               brk,
   // Interrupt
   output logic             irq_q
);

   // ************************************************************
   // Helpers
   // ************************************************************

   // Byte-lane merge of a write into a word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] stb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (stb[i]) r[8*i +: 8] = nw[8*i +: 8];
      end
      return r;
   endfunction

   // ************************************************************
   // State
   // ************************************************************
   logic [7:0]  aw_adr_q;
   logic        aw_full_q;
   logic [31:0] w_dat_q;
   logic [3:0]  w_stb_q;
   logic        w_full_q;
   logic [31:0] ctrl_q;
   logic [31:0] addr_q;
   logic [7:0]  rd_q;
   logic        rd_pend_q;
   logic [15:0] vec_q;
   logic        in_brk_q;
   logic        wx_q;
   logic [2:0]  ist_q;
   logic [2:0]  imask_q;

   // ************************************************************
   // Decode
   // ************************************************************
   wire         wr_go   = aw_full_q & w_full_q & ~s_axil_bvalid;
   wire         wr_ctrl = wr_go & (aw_adr_q == H_CTRL);
   wire         wr_addr = wr_go & (aw_adr_q == H_ADDR);
   wire         wr_ist  = wr_go & (aw_adr_q == H_ISTAT);
   wire         wr_imsk = wr_go & (aw_adr_q == H_IMASK);
   wire         wr_map  = wr_ctrl | wr_addr | wr_ist | wr_imsk | (aw_adr_q == H_STAT);
   wire [31:0]  cw      = merge(32'h0, w_dat_q, w_stb_q);
   wire [31:0]  ctrl_w  = merge(ctrl_q, w_dat_q, w_stb_q);
   wire         go      = wr_ctrl & cw[C_GO];
   wire         return_from_interrupt_instr     = wr_ctrl & cw[C_RTI] & in_brk_q;
   wire         take    = brk.break_req & ~in_brk_q;

   // Interrupt events, set wins over a one-to-clear write
   wire [2:0]   ev    = {(go & (ctrl_w[C_WR] | ctrl_w[C_PC])) | rd_pend_q, return_from_interrupt_instr, take};
   wire [2:0]   w1c   = wr_ist ? cw[2:0] : 3'h0;
   wire [2:0]   ist_d = (ist_q & ~w1c) | ev;

   // Read select
   wire [31:0]  stat_rd = {vec_q, 5'h00, wx_q, in_brk_q, 1'b0, rd_q};
   wire         rd_map  = (s_axil_araddr == H_CTRL) | (s_axil_araddr == H_ADDR) |
                          (s_axil_araddr == H_STAT) | (s_axil_araddr == H_ISTAT) |
                          (s_axil_araddr == H_IMASK);
   wire [31:0]  rd_mux  = (s_axil_araddr == H_CTRL)  ? ctrl_q :
                          (s_axil_araddr == H_ADDR)  ? addr_q :
                          (s_axil_araddr == H_STAT)  ? stat_rd :
                          (s_axil_araddr == H_ISTAT) ? {29'h0, ist_q} :
                          (s_axil_araddr == H_IMASK) ? {29'h0, imask_q} : 32'h0;

   // ************************************************************
   // AXI4-Lite slave
   // ************************************************************
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         aw_adr_q <= 8'h00; aw_full_q <= 1'b0; s_axil_awready <= 1'b1;
         w_dat_q <= 32'h0; w_stb_q <= 4'h0; w_full_q <= 1'b0; s_axil_wready <= 1'b1;
         s_axil_bvalid <= 1'b0; s_axil_bresp <= RESP_OKAY;
         s_axil_arready <= 1'b1; s_axil_rvalid <= 1'b0;
         s_axil_rdata <= 32'h0; s_axil_rresp <= RESP_OKAY;
      end else begin
         if (s_axil_awvalid && s_axil_awready) begin
            aw_adr_q <= s_axil_awaddr; aw_full_q <= 1'b1; s_axil_awready <= 1'b0;
         end
         if (s_axil_wvalid && s_axil_wready) begin
            w_dat_q <= s_axil_wdata; w_stb_q <= s_axil_wstrb;
            w_full_q <= 1'b1; s_axil_wready <= 1'b0;
         end
         if (wr_go) begin
            aw_full_q <= 1'b0; w_full_q <= 1'b0; s_axil_bvalid <= 1'b1;
            s_axil_bresp <= wr_map ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axil_bvalid && s_axil_bready) begin
            s_axil_bvalid <= 1'b0; s_axil_awready <= 1'b1; s_axil_wready <= 1'b1;
         end
         if (s_axil_arvalid && s_axil_arready) begin
            s_axil_arready <= 1'b0; s_axil_rvalid <= 1'b1; s_axil_rdata <= rd_mux;
            s_axil_rresp <= rd_map ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axil_rvalid && s_axil_rready) begin
            s_axil_rvalid <= 1'b0; s_axil_arready <= 1'b1;
         end
      end
   end

   // ************************************************************
   // Core behaviour toward the break unit
   // ************************************************************
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q <= 32'h0; addr_q <= 32'h0; rd_q <= 8'h00; rd_pend_q <= 1'b0;
         vec_q <= 16'h0000; in_brk_q <= 1'b0; wx_q <= 1'b0;
         ist_q <= 3'h0; imask_q <= 3'h0; irq_q <= 1'b0;
         brk.addr <= 16'h0000; brk.wdata <= 8'h00; brk.pc_fetch <= 1'b0;
         brk.wr_en <= 1'b0; brk.rd_en <= 1'b0; brk.rti_done <= 1'b0;
         brk.wait_mode <= 1'b0; brk.stop_mode <= 1'b0;
      end else begin
         // One-cycle bus strobes
         brk.wr_en    <= go & ctrl_w[C_WR];
         brk.pc_fetch <= go & ~ctrl_w[C_WR] & ctrl_w[C_PC];
         brk.rd_en    <= go & ~ctrl_w[C_WR] & ~ctrl_w[C_PC];
         brk.rti_done <= return_from_interrupt_instr;  // R6
         rd_pend_q    <= brk.rd_en;
         if (rd_pend_q) rd_q <= brk.rdata;
         if (go) begin
            brk.addr  <= addr_q[15:0];
            brk.wdata <= addr_q[23:16];
         end
         if (wr_addr) addr_q <= merge(addr_q, w_dat_q, w_stb_q);
         if (wr_ctrl) begin
            ctrl_q <= {ctrl_w[31:C_RTI+1], 1'b0, ctrl_w[C_MON:C_GO+1], 1'b0};
            brk.wait_mode <= ctrl_w[C_WAIT];
            brk.stop_mode <= ctrl_w[C_STOP];
         end
         // Break taken at once with the mode's vector
         if (take) begin
            in_brk_q <= 1'b1;  // R5
            vec_q    <= ctrl_q[C_MON] ? VEC_MON : VEC_USER;  // R2
            wx_q     <= brk.wait_mode;  // R15
            brk.wait_mode <= 1'b0;
            ctrl_q[C_WAIT] <= 1'b0;
         end else if (return_from_interrupt_instr) begin
            in_brk_q <= 1'b0;  // R6
         end
         ist_q   <= ist_d;
         if (wr_imsk) imask_q <= cw[2:0];
         irq_q   <= |(ist_d & (wr_imsk ? cw[2:0] : imask_q));
      end
   end

endmodule

// ### verif/abm_properties.sv
// Purpose: Concurrent checks on the CPU to break unit connection
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Mirrors break address, enable and break state from observed traffic

`timescale 1ns/1ps

module abm_properties
   import abm_pkg::*;
(
   // Clock and reset
   input wire logic        ref_clk,
   input wire logic        rst_b,
   // Connection signals
   input wire logic [15:0] addr,
   input wire logic        pc_fetch,
   input wire logic        wr_en,
   input wire logic        rd_en,
   input wire logic [7:0]  wdata,
   input wire logic        wait_mode,
   input wire logic        stop_mode,
   input wire logic        rti_done,
   input wire logic [7:0]  rdata,
   input wire logic        break_req
);
   // ************************************************************
   // Mirror of break unit state
   // ************************************************************
   logic [7:0] bah_q;
   logic [7:0] bal_q;
   logic       en_q;
   logic       in_brk_q;
   logic       wr_ok;

   // Writes count only outside stop mode
   assign wr_ok = wr_en && !stop_mode;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   // Track written address bytes, enable bit and break state
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         bah_q    <= 8'h00;
         bal_q    <= 8'h00;
         en_q     <= 1'b0;
         in_brk_q <= 1'b0;
      end else begin
         if (wr_ok && addr == ADR_BAH) bah_q <= wdata;
         if (wr_ok && addr == ADR_BAL) bal_q <= wdata;
         if (wr_ok && addr == ADR_SCR) en_q <= wdata[SCR_ENA_BIT];
         if (break_req) in_brk_q <= 1'b1;
         else if (rti_done) in_brk_q <= 1'b0;
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   a_match_break: assert property (pc_fetch && !stop_mode && en_q && !in_brk_q &&
      addr == {bah_q, bal_q} |=> break_req)
      else $error("matching fetch gave no break request");
   a_no_match: assert property (pc_fetch && !wr_en &&
      (!en_q || addr != {bah_q, bal_q}) |=> !break_req)
      else $error("break request without enabled match");
   a_force_break: assert property (wr_ok && addr == ADR_SCR &&
      wdata[SCR_ACT_BIT] && !in_brk_q |=> break_req)
      else $error("active bit write gave no break request");
   a_req_cause: assert property (break_req |-> $past(pc_fetch) || $past(wr_en))
      else $error("break request without fetch or write");
   a_req_pulse: assert property (break_req |=> !break_req)
      else $error("break request longer than one cycle");
   a_no_rebreak: assert property (in_brk_q && !rti_done |=> !break_req)
      else $error("break request while in break");
   a_stop_quiet: assert property (stop_mode |=> !break_req)
      else $error("break request in stop mode");
   a_rdata_idle: assert property (!rd_en |=> rdata == 8'h00)
      else $error("read data without read");
   a_addr_read: assert property (rd_en && addr == ADR_BAH |=> rdata == bah_q)
      else $error("address high byte read back wrong");
endmodule

// ### verif/testbench.sv
// Purpose: Drives the CPU end over AXI4-Lite and checks the break unit
// Assumes: Both ends joined by one abm_if, test voltage present except during the watchdog-on check
// Notes:   Device registers reached through go commands of the CPU end

`timescale 1ns/1ps

module testbench
   import abm_pkg::*;
;
   // ************************************************************
   // Signals
   // ************************************************************
   localparam logic [6:0] WRC = 7'h1 << C_WR;
   localparam logic [6:0] PCC = 7'h1 << C_PC;
   logic        ref_clk = 1'b0;
   logic        rst_b, tv, aw_v, awrdy, w_v, wrdy, bvld, b_r, ar_v, arrdy, rvld, r_r;
   logic        irq, bst, thalt, wdog, sclr;
   logic [7:0]  aw_a, ar_a;
   logic [31:0] w_d, r_d, v;
   logic [1:0]  b_rsp, r_rsp, rsp;
   logic [6:0]  md;
   int          miscompares = 0;
   int          checks = 0;

   abm_if bus ();
   abm_brk_unit u_abm_brk_unit (.ref_clk(ref_clk), .rst_b(rst_b), .cpu(bus),
      .test_voltage(tv), .break_state_q(bst), .timer_halt_q(thalt),
      .watchdog_off_q(wdog), .status_clear_ok_q(sclr));
   abm_cpu_end u_abm_cpu_end (.ref_clk(ref_clk), .rst_b(rst_b), .s_axil_awaddr(aw_a),
      .s_axil_awvalid(aw_v), .s_axil_awready(awrdy), .s_axil_wdata(w_d),
      .s_axil_wstrb(4'hf), .s_axil_wvalid(w_v), .s_axil_wready(wrdy),
      .s_axil_bresp(b_rsp), .s_axil_bvalid(bvld), .s_axil_bready(b_r),
      .s_axil_araddr(ar_a), .s_axil_arvalid(ar_v), .s_axil_arready(arrdy),
      .s_axil_rdata(r_d), .s_axil_rresp(r_rsp), .s_axil_rvalid(rvld),
      .s_axil_rready(r_r), .brk(bus), .irq_q(irq));
   abm_properties u_abm_properties (.ref_clk(ref_clk), .rst_b(rst_b), .addr(bus.addr),
      .pc_fetch(bus.pc_fetch), .wr_en(bus.wr_en), .rd_en(bus.rd_en),
      .wdata(bus.wdata), .wait_mode(bus.wait_mode), .stop_mode(bus.stop_mode),
      .rti_done(bus.rti_done), .rdata(bus.rdata), .break_req(bus.break_req));

   // Clock of 8 ns period
   always #4 ref_clk = ~ref_clk;

   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checks++;
      if (s !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask

   // AXI write: both channels offered together, each released when taken
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      aw_a <= a;
      w_d  <= d;
      aw_v <= 1'b1;
      w_v  <= 1'b1;
      b_r  <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (awrdy) aw_v <= 1'b0;
         if (wrdy) w_v <= 1'b0;
      end while (!bvld);
      rsp = b_rsp;
      b_r <= 1'b0;
   endtask

   // AXI read: result in v and rsp
   task automatic axr(input logic [7:0] a);
      @(posedge ref_clk);
      ar_a <= a;
      ar_v <= 1'b1;
      r_r  <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (arrdy) ar_v <= 1'b0;
      end while (!rvld);
      v   = r_d;
      rsp = r_rsp;
      r_r <= 1'b0;
   endtask

   // Device access through the CPU end, held modes in md
   task automatic op(input logic [6:0] c, input logic [15:0] a, input logic [7:0] d);
      axw(H_ADDR, {8'h00, d, a});
      axw(H_CTRL, {25'h0, md | c | (7'h1 << C_GO)});
      repeat (4) @(posedge ref_clk);
   endtask

   task automatic dr(input logic [15:0] a, input logic [7:0] e);
      op(7'h00, a, 8'h00);
      axr(H_STAT);
      chk("device byte", {24'h0, e}, {24'h0, v[7:0]});
   endtask

   task automatic st(input logic b);
      axr(H_STAT);
      chk("in break", {31'h0, b}, {31'h0, v[9]});
   endtask

   // Return from break and clear pending events
   task automatic leave();
      axw(H_CTRL, {25'h0, md | (7'h1 << C_RTI)});
      repeat (4) @(posedge ref_clk);
      axw(H_ISTAT, 32'h0000_0007);
   endtask

   task automatic conclude();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // Watchdog against a hang
   initial begin
      repeat (20000) @(posedge ref_clk);
      miscompares++;
      conclude();
   end

   // ************************************************************
   // Tests
   // ************************************************************
   initial begin
      rst_b = 1'b0;
      tv = 1'b1;
      {aw_v, w_v, b_r, ar_v, r_r, aw_a, ar_a, w_d} = 53'h0;
      md = 7'h00;
      repeat (6) @(posedge ref_clk);
      rst_b <= 1'b1;
      dr(ADR_SCR, 8'h00);
      dr(ADR_BAH, 8'h00);
      dr(ADR_BAL, 8'h00);
      dr(ADR_WST, 8'h00);
      dr(ADR_FCR, 8'h00);
      $display("test reset done");
      op(WRC, ADR_BAH, 8'h12);
      op(WRC, ADR_BAL, 8'h34);
      op(WRC, ADR_SCR, 8'h80);
      op(PCC, 16'h1233, 8'h00);
      st(1'b0);
      op(PCC, 16'h1234, 8'h00);
      st(1'b1);
      chk("vector", {16'h0, VEC_USER}, {16'h0, v[31:16]});
      chk("irq masked", 32'h0, {31'h0, irq});
      axw(H_IMASK, 32'h0000_0001);
      repeat (2) @(posedge ref_clk);
      chk("irq", 32'h1, {31'h0, irq});
      chk("timer halt", 32'h1, {31'h0, thalt});
      chk("watchdog off", 32'h1, {31'h0, wdog});
      chk("clear ok", 32'h0, {31'h0, sclr});
      tv <= 1'b0;
      dr(ADR_SCR, 8'hc0);
      chk("watchdog on", 32'h0, {31'h0, wdog});
      tv <= 1'b1;
      op(WRC, ADR_FCR, 8'h80);
      chk("clear ok", 32'h1, {31'h0, sclr});
      op(WRC, ADR_SCR, 8'h80);
      leave();
      chk("break state", 32'h0, {31'h0, bst});
      chk("timer halt", 32'h0, {31'h0, thalt});
      chk("irq cleared", 32'h0, {31'h0, irq});
      $display("test match done");
      op(WRC, ADR_SCR, 8'h00);
      op(PCC, 16'h1234, 8'h00);
      st(1'b0);
      op(WRC, ADR_SCR, 8'h80);
      op(7'h00, 16'h1234, 8'h00);
      st(1'b0);
      $display("test gating done");
      md = 7'h1 << C_MON;
      op(WRC, ADR_SCR, 8'h40);
      st(1'b1);
      chk("vector", {16'h0, VEC_MON}, {16'h0, v[31:16]});
      op(WRC, ADR_SCR, 8'h80);
      md = 7'h00;
      leave();
      $display("test force done");
      md = 7'h1 << C_WAIT;
      op(PCC, 16'h1234, 8'h00);
      md = 7'h00;
      dr(ADR_WST, 8'h02);
      chk("left wait", 32'h1, {31'h0, v[10]});
      op(WRC, ADR_WST, 8'h00);
      dr(ADR_WST, 8'h00);
      op(WRC, ADR_SCR, 8'h80);
      leave();
      $display("test wait done");
      md = 7'h1 << C_STOP;
      op(WRC, ADR_BAH, 8'hff);
      op(PCC, 16'h1234, 8'h00);
      st(1'b0);
      dr(ADR_BAH, 8'h12);
      md = 7'h00;
      dr(ADR_SCR, 8'h80);
      $display("test stop done");
      axw(8'h20, 32'h0000_0001);
      chk("write resp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
      axr(8'h20);
      chk("read resp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
      $display("test unmapped done");
      conclude();
   end
endmodule
